//--- hdl/vfm_pkg.sv
package vfm_pkg;

  // ****************************************
  // Map geometry
  // ****************************************
  localparam int MAP_DEPTH = 84;
  localparam int CODE_W = 7;
  localparam int ADDR_W = 7;
  localparam logic [6:0] MAP_LAST = 7'h53;
  localparam logic [6:0] PTR_LOCKED = 7'h54;
  localparam logic [6:0] PTR_RESET = 7'h00;

  // ****************************************
  // Host command port
  // ****************************************
  localparam logic [7:0] ADDR_MAP_PORT = 8'h06;
  localparam logic [7:0] ADDR_MAP_READ = 8'h86;
  localparam logic [7:0] ADDR_SHIFT_LIMIT = 8'h0e;
  localparam int PTR_LOAD_BIT = 7;
  localparam logic [6:0] SHIFT_LIMIT_RESET = 7'h53;

  // ****************************************
  // Entry codes
  // ****************************************
  localparam logic [6:0] CODE_ROW1_FIRST = 7'd48;
  localparam logic [6:0] CODE_ROW1_LAST = 7'd64;
  localparam logic [6:0] CODE_ROW2_FIRST = 7'd65;
  localparam logic [6:0] CODE_ROW2_LAST = 7'd81;
  localparam logic [6:0] CODE_ANN_FIRST = 7'd82;
  localparam logic [6:0] CODE_ANN_LAST = 7'd85;
  localparam logic [6:0] CODE_CURSOR1 = 7'd86;
  localparam logic [6:0] CODE_CURSOR2 = 7'd87;
  localparam int SEG_COUNT = 17;
  localparam int ANN_COUNT = 4;
  localparam int GRID_W = 6;

  // ****************************************
  // Power-up pattern
  // ****************************************
  localparam logic [6:0] DEFAULT_GRID_SPAN = 7'd40;
  localparam logic [6:0] DEFAULT_CODE_SKIP = 7'd8;

endpackage

//--- hdl/vfm_func_if.sv
`timescale 1ns/1ps
interface vfm_func_if;
  logic [vfm_pkg::CODE_W-1:0] code;
  logic twoRowMode;
  logic [vfm_pkg::GRID_W-1:0] activeGrid;
  logic [vfm_pkg::SEG_COUNT-1:0] row1Segments;
  logic [vfm_pkg::SEG_COUNT-1:0] row2Segments;
  logic [vfm_pkg::ANN_COUNT-1:0] annunciators;
  logic row1Cursor;
  logic row2Cursor;
  logic bitValue;

  modport source (
    output code, twoRowMode, activeGrid, row1Segments, row2Segments,
    output annunciators, row1Cursor, row2Cursor,
    input bitValue
  );
  modport decoder (
    input code, twoRowMode, activeGrid, row1Segments, row2Segments,
    input annunciators, row1Cursor, row2Cursor,
    output bitValue
  );
endinterface

//--- hdl/vfm_map_ram.sv
`timescale 1ns/1ps
module vfm_map_ram #(
  parameter int DEPTH = vfm_pkg::MAP_DEPTH,
  parameter int WIDTH = vfm_pkg::CODE_W,
  parameter int AW = vfm_pkg::ADDR_W
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] hostAddr,
  input wire logic hostWe,
  input wire logic [WIDTH-1:0] hostWrData,
  output logic [WIDTH-1:0] hostRdData,
  input wire logic [AW-1:0] scanAddr,
  output logic [WIDTH-1:0] scanRdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ****************************************
  // Storage with power-up pattern
  // ****************************************
  // Kept in flops so a reset restores the default pattern.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (i < int'(vfm_pkg::DEFAULT_GRID_SPAN))
          mem[i] <= WIDTH'(i);
        else
          mem[i] <= WIDTH'(i + int'(vfm_pkg::DEFAULT_CODE_SKIP));
      end
    end
    else if (hostWe && (int'(hostAddr) < DEPTH))
    begin
      mem[hostAddr] <= hostWrData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hostRdData <= '0;
    else if (int'(hostAddr) < DEPTH)
      hostRdData <= mem[hostAddr];
    else
      hostRdData <= '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      scanRdData <= '0;
    else if (int'(scanAddr) < DEPTH)
      scanRdData <= mem[scanAddr];
    else
      scanRdData <= '0;
  end

endmodule

//--- hdl/vfm_code_decode.sv
`timescale 1ns/1ps
module vfm_code_decode (
  vfm_func_if.decoder fn
);

  // ****************************************
  // Code to display function
  // ****************************************
  always_comb
  begin
    logic [6:0] offset;
    offset = '0;
    fn.bitValue = 1'b0;
    if (fn.code < vfm_pkg::CODE_ROW1_FIRST)
    begin
      fn.bitValue = (fn.code[5:0] == fn.activeGrid);
    end
    else if (fn.code <= vfm_pkg::CODE_ROW1_LAST)
    begin
      offset = fn.code - vfm_pkg::CODE_ROW1_FIRST;
      fn.bitValue = fn.row1Segments[offset[4:0]];
    end
    else if (fn.code <= vfm_pkg::CODE_ROW2_LAST)
    begin
      offset = fn.code - vfm_pkg::CODE_ROW2_FIRST;
      fn.bitValue = fn.twoRowMode && fn.row2Segments[offset[4:0]];
    end
    else if (fn.code <= vfm_pkg::CODE_ANN_LAST)
    begin
      offset = fn.code - vfm_pkg::CODE_ANN_FIRST;
      fn.bitValue = !fn.twoRowMode && fn.annunciators[offset[1:0]];
    end
    else if (fn.code == vfm_pkg::CODE_CURSOR1)
    begin
      fn.bitValue = fn.row1Cursor;
    end
    else if (fn.code == vfm_pkg::CODE_CURSOR2)
    begin
      fn.bitValue = fn.twoRowMode && fn.row2Cursor;
    end
  end

endmodule

//--- hdl/vfm_output_map.sv
// How it works
// - Map holds 84 seven-bit entries
// - Positions zero to shift limit use entries
// - Codes 0-47 select grids
// - Codes 48-64 select first-row segments
// - Codes 65-81 second row, two-row only
// - Codes 82-85 annunciators, single-row only
// - Code 86/87 select row cursors
// - Unused codes 88-127 drive low
// - Codes invalid for row mode drive low
// - Missing font segments give zero
// - Pointer at 0x06, write only
// - Out-of-range pointer loads give zero
// - Data write stores, then pointer increments
// - Writes ignored after 0x53 until reload
// - Pointer resets to zero
// - Read 0x86 returns entry, then increments
// - Reset map drives 40-digit two-row display
// - Default: grids 0-39, then codes 48+
// - Shift limit above 0x53 stores 0x53
`timescale 1ns/1ps
module vfm_output_map (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdWrData,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic [6:0] shiftLimit,
  input wire logic twoRowMode,
  input wire logic [vfm_pkg::GRID_W-1:0] activeGrid,
  input wire logic [vfm_pkg::SEG_COUNT-1:0] row1Segments,
  input wire logic [vfm_pkg::SEG_COUNT-1:0] row2Segments,
  input wire logic [vfm_pkg::ANN_COUNT-1:0] annunciators,
  input wire logic row1Cursor,
  input wire logic row2Cursor,
  input wire logic frameStart,
  output logic scanBusy,
  output logic outValid,
  output logic outBit,
  output logic [6:0] outIndex,
  output logic outLast
);

  logic [6:0] mapPointer;
  logic [6:0] next_mapPointer;
  logic mapWrite;
  logic mapRead;
  logic ptrLoad;
  logic limitWrite;
  logic readPending;
  logic [6:0] hostRdCode;
  logic [6:0] scanPos;
  logic [6:0] scanCode;
  logic stageValid;
  logic stageLast;
  logic [6:0] stageIndex;
  logic scanAtLimit;
  logic frameTwoRow;
  logic [vfm_pkg::GRID_W-1:0] frameGrid;
  logic [vfm_pkg::SEG_COUNT-1:0] frameRow1;
  logic [vfm_pkg::SEG_COUNT-1:0] frameRow2;
  logic [vfm_pkg::ANN_COUNT-1:0] frameAnn;
  logic frameCursor1;
  logic frameCursor2;

  vfm_func_if fnBus ();

  // ****************************************
  // Command decode
  // ****************************************
  assign ptrLoad = cmdValid && cmdWrite && (cmdAddr == vfm_pkg::ADDR_MAP_PORT)
                   && cmdWrData[vfm_pkg::PTR_LOAD_BIT];
  // The locked value sits one past the last entry, so it doubles as the stop flag.
  assign mapWrite = cmdValid && cmdWrite && (cmdAddr == vfm_pkg::ADDR_MAP_PORT)
                    && !cmdWrData[vfm_pkg::PTR_LOAD_BIT]
                    && (mapPointer != vfm_pkg::PTR_LOCKED);
  assign mapRead = cmdValid && !cmdWrite && (cmdAddr == vfm_pkg::ADDR_MAP_READ)
                   && (mapPointer != vfm_pkg::PTR_LOCKED);
  assign limitWrite = cmdValid && cmdWrite && (cmdAddr == vfm_pkg::ADDR_SHIFT_LIMIT);

  // ****************************************
  // Address pointer
  // ****************************************
  always_comb
  begin
    next_mapPointer = mapPointer;
    if (ptrLoad)
    begin
      if (cmdWrData[6:0] > vfm_pkg::MAP_LAST)
        next_mapPointer = vfm_pkg::PTR_RESET;
      else
        next_mapPointer = cmdWrData[6:0];
    end
    else if (mapWrite || mapRead)
    begin
      next_mapPointer = mapPointer + 7'h01;
    end
  end

  // The pointer has no read path at all; only the entry it selects is visible.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      mapPointer <= vfm_pkg::PTR_RESET;
    else
      mapPointer <= next_mapPointer;
  end

  // ****************************************
  // Shift limit
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      shiftLimit <= vfm_pkg::SHIFT_LIMIT_RESET;
    else if (limitWrite)
    begin
      if (cmdWrData > {1'b0, vfm_pkg::MAP_LAST})
        shiftLimit <= vfm_pkg::MAP_LAST;
      else
        shiftLimit <= cmdWrData[6:0];
    end
  end

  // ****************************************
  // Host read-back
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rdValid <= 1'b0;
      readPending <= 1'b0;
    end
    else
    begin
      rdValid <= cmdValid && !cmdWrite;
      readPending <= mapRead;
    end
  end

  // Every read answers one cycle later; only a live map read carries an entry.
  always_comb
  begin
    if (readPending)
      rdData = {1'b0, hostRdCode};
    else
      rdData = 8'h00;
  end

  // ****************************************
  // Map storage
  // ****************************************
  vfm_map_ram #(
    .DEPTH(vfm_pkg::MAP_DEPTH),
    .WIDTH(vfm_pkg::CODE_W),
    .AW(vfm_pkg::ADDR_W)
  ) mapRam (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .hostAddr(mapPointer),
    .hostWe(mapWrite),
    .hostWrData(cmdWrData[6:0]),
    .hostRdData(hostRdCode),
    .scanAddr(scanPos),
    .scanRdData(scanCode)
  );

  // ****************************************
  // Position scan
  // ****************************************
  assign scanAtLimit = (scanPos == shiftLimit);

  // A new frame restarts the walk even if the previous one has not finished.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      scanBusy <= 1'b0;
      scanPos <= '0;
    end
    else if (frameStart)
    begin
      scanBusy <= 1'b1;
      scanPos <= '0;
    end
    else if (scanBusy)
    begin
      if (scanAtLimit)
        scanBusy <= 1'b0;
      else
        scanPos <= scanPos + 7'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      stageValid <= 1'b0;
    else
      stageValid <= scanBusy && !frameStart;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      stageLast <= 1'b0;
    else
      stageLast <= scanBusy && !frameStart && scanAtLimit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      stageIndex <= '0;
    else
      stageIndex <= scanPos;
  end

  // ****************************************
  // Frame snapshot
  // ****************************************
  // The display inputs are captured as a frame starts, so an upstream change in
  // mid-walk cannot tear one bitstream between two grids.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      frameTwoRow <= 1'b0;
      frameGrid <= '0;
      frameRow1 <= '0;
      frameRow2 <= '0;
      frameAnn <= '0;
      frameCursor1 <= 1'b0;
      frameCursor2 <= 1'b0;
    end
    else if (frameStart)
    begin
      frameTwoRow <= twoRowMode;
      frameGrid <= activeGrid;
      frameRow1 <= row1Segments;
      frameRow2 <= row2Segments;
      frameAnn <= annunciators;
      frameCursor1 <= row1Cursor;
      frameCursor2 <= row2Cursor;
    end
  end

  // ****************************************
  // Function select
  // ****************************************
  assign fnBus.code = scanCode;
  assign fnBus.twoRowMode = frameTwoRow;
  assign fnBus.activeGrid = frameGrid;
  assign fnBus.row1Segments = frameRow1;
  assign fnBus.row2Segments = frameRow2;
  assign fnBus.annunciators = frameAnn;
  assign fnBus.row1Cursor = frameCursor1;
  assign fnBus.row2Cursor = frameCursor2;

  vfm_code_decode decode (
    .fn(fnBus.decoder)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      outValid <= 1'b0;
    else
      outValid <= stageValid;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      outBit <= 1'b0;
    else
      outBit <= stageValid && fnBus.bitValue;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      outIndex <= '0;
    else
      outIndex <= stageIndex;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      outLast <= 1'b0;
    else
      outLast <= stageLast;
  end

endmodule

//--- sim/vfm_output_map_properties.sv
`timescale 1ns/1ps
module vfm_output_map_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdWrData,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  input wire logic [6:0] shiftLimit,
  input wire logic frameStart,
  input wire logic scanBusy,
  input wire logic outValid,
  input wire logic [6:0] outIndex,
  input wire logic outLast
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  read_answer_a: assert property (cmdValid && !cmdWrite |=> rdValid)
    else $error("read not answered");
  read_cause_a: assert property (rdValid |-> $past(cmdValid && !cmdWrite))
    else $error("answer without read");
  read_msb_a: assert property (rdValid |-> !rdData[7])
    else $error("read msb set");
  limit_sat_a: assert property (cmdValid && cmdWrite && cmdAddr == 8'h0e |=>
    shiftLimit == ($past(cmdWrData) > 8'h53 ? 7'h53 : $past(cmdWrData[6:0])))
    else $error("shift limit wrong");
  first_pos_a: assert property (frameStart ##1 (!frameStart)[*2] |=>
    outValid && outIndex == 7'h00)
    else $error("first position late");
  walk_busy_a: assert property (frameStart |=> scanBusy)
    else $error("walk not busy");
  last_match_a: assert property (outValid |-> outLast == (outIndex == shiftLimit))
    else $error("last flag wrong");
  last_valid_a: assert property (outLast |-> outValid)
    else $error("last without valid");
  index_step_a: assert property (outValid && !outLast && !frameStart |=>
    outValid && outIndex == $past(outIndex) + 7'h01)
    else $error("index skipped");
endmodule

//--- sim/vfm_host.sv
`timescale 1ns/1ps
module vfm_host (
  input wire logic sys_clk,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdAddr,
  output logic [7:0] cmdWrData,
  input wire logic rdValid,
  input wire logic [7:0] rdData
);
  logic [7:0] lastRead;
  initial
  begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = 8'h00;
    cmdWrData = 8'h00;
  end
  // Released address and data lines show the inverse so a stale value is never mistaken for a command.
  task automatic send(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdAddr = a;
    cmdWrData = d;
    @(posedge sys_clk);
    #1;
    lastRead = rdValid ? rdData : 8'hxx;
    cmdValid = 1'b0;
    cmdAddr = ~a;
    cmdWrData = ~d;
  endtask
  task automatic load(input logic [7:0] v);
    send(1'b1, 8'h06, v | 8'h80);
  endtask
  task automatic put(input logic [6:0] d);
    send(1'b1, 8'h06, {1'b0, d});
  endtask
  task automatic get(output logic [7:0] d);
    send(1'b0, 8'h86, 8'h00);
    d = lastRead;
  endtask
endmodule

//--- sim/vfm_output_map_bench.sv
`timescale 1ns/1ps
module vfm_output_map_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid, cmdWrite, rdValid, twoRowMode, row1Cursor, row2Cursor, frameStart;
  logic scanBusy, outValid, outBit, outLast;
  logic [7:0] cmdAddr, cmdWrData, rdData, got, a;
  logic [6:0] shiftLimit, outIndex, lim;
  logic [5:0] activeGrid;
  logic [16:0] row1Segments, row2Segments;
  logic [3:0] annunciators;
  logic [6:0] m [84];
  logic [31:0] seed = 32'h43;
  int n_errors = 0;
  int comparisons = 0;
  int i, t;
  always #2.5 sys_clk = ~sys_clk;
  vfm_output_map dut (.sys_clk, .rst_n, .cmdValid, .cmdWrite, .cmdAddr, .cmdWrData, .rdValid,
    .rdData, .shiftLimit, .twoRowMode, .activeGrid, .row1Segments, .row2Segments,
    .annunciators, .row1Cursor, .row2Cursor, .frameStart, .scanBusy, .outValid, .outBit,
    .outIndex, .outLast);
  vfm_host host (.sys_clk, .cmdValid, .cmdWrite, .cmdAddr, .cmdWrData, .rdValid, .rdData);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic expBit(input logic [6:0] c);
    if (c < 7'd48) return c[5:0] == activeGrid;
    if (c <= 7'd64) return row1Segments[c - 7'd48];
    if (c <= 7'd81) return twoRowMode & row2Segments[c - 7'd65];
    if (c <= 7'd85) return !twoRowMode & annunciators[c - 7'd82];
    if (c == 7'd86) return row1Cursor;
    if (c == 7'd87) return twoRowMode & row2Cursor;
    return 1'b0;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****
  // Walk
  // ****
  task automatic scan();
    int k;
    int j;
    k = 0;
    @(posedge sys_clk);
    #1 frameStart = 1'b1;
    @(posedge sys_clk);
    #1 frameStart = 1'b0;
    for (j = 0; j < 200 && k <= lim; j++)
    begin
      @(posedge sys_clk);
      #1;
      if (outValid)
      begin
        chk({1'b0, outIndex}, k[7:0]);
        chk({7'h00, outBit}, {7'h00, expBit(m[k])});
        chk({7'h00, outLast}, {7'h00, (k == lim)});
        k++;
      end
    end
    chk(k[7:0], {1'b0, lim} + 8'h01);
  endtask
  initial
  begin
    frameStart = 1'b0;
    twoRowMode = 1'(rnd());
    activeGrid = 6'(rnd() % 48);
    {row1Segments, row2Segments} = 34'({rnd(), rnd()});
    {annunciators, row1Cursor, row2Cursor} = 6'(rnd());
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk({1'b0, shiftLimit}, 8'h53);
    for (i = 0; i < 84; i++)
    begin
      host.get(got);
      chk(got, i < 40 ? i[7:0] : i[7:0] + 8'd8);
    end
    host.get(got);
    chk(got, 8'h00);
    host.put(7'h11);
    host.load(8'h00);
    host.get(got);
    chk(got, 8'h00);
    $display("test defaults done");
    host.load(8'h00);
    host.put(7'h55);
    a = 8'hd4 + 8'(rnd() % 44);
    host.send(1'b1, 8'h06, a);
    host.get(got);
    chk(got, 8'h55);
    host.get(got);
    chk(got, 8'h01);
    host.send(1'b0, 8'h06, 8'h00);
    chk(host.lastRead, 8'h00);
    host.get(got);
    chk(got, 8'h02);
    host.load(8'h52);
    host.put(7'h2a);
    host.put(7'h7f);
    host.put(7'h33);
    host.load(8'h52);
    host.get(got);
    chk(got, 8'h2a);
    host.get(got);
    chk(got, 8'h7f);
    host.get(got);
    chk(got, 8'h00);
    $display("test pointer done");
    host.send(1'b1, 8'h0e, 8'h54 + 8'(rnd() % 172));
    chk({1'b0, shiftLimit}, 8'h53);
    for (t = 0; t < 6; t++)
    begin
      lim = t == 0 ? 7'd83 : (t == 1 ? 7'd1 : 7'(rnd() % 24));
      host.send(1'b1, 8'h0e, {1'b0, lim});
      chk({1'b0, shiftLimit}, {1'b0, lim});
      twoRowMode = t[0];
      activeGrid = 6'(rnd() % 48);
      {row1Segments, row2Segments} = 34'({rnd(), rnd()});
      {annunciators, row1Cursor, row2Cursor} = 6'(rnd());
      host.load(8'h00);
      for (i = 0; i <= lim; i++)
      begin
        m[i] = i == 0 ? {1'b0, activeGrid} : (i[0] ? 7'd48 + 7'(rnd() % 40) : 7'(rnd()));
        host.put(m[i]);
      end
      scan();
      $display("test walk %0d done", t);
    end
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk({1'b0, shiftLimit}, 8'h53);
    host.get(got);
    chk(got, 8'h00);
    host.get(got);
    chk(got, 8'h01);
    host.load(8'h28);
    host.get(got);
    chk(got, 8'h30);
    $display("test reset done");
    complete_run();
  end
  initial
  begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule
bind vfm_output_map vfm_output_map_properties chk (.sys_clk, .rst_n, .cmdValid, .cmdWrite,
  .cmdAddr, .cmdWrData, .rdValid, .rdData, .shiftLimit, .frameStart, .scanBusy, .outValid,
  .outIndex, .outLast);
